// >>> pads_regs.svh
// Register offsets, field positions, reset values for the port analog/direction block
// Assumes an 8-bit register port with a flat byte address space
// Overview of operation
// - Bits 5-0 of port_b_analog_select make their pins analog inputs with the digital input off, and reset to 1.
// - Bits 7-6 of port_b_analog_select always read zero and ignore writes.
// - A zero analog bit hands the pin to port logic or a digital peripheral with its input buffer on.
// - Each port_d_direction bit set to 1 makes its pin an input, 0 enables the driver, all reset to 1.
// - On reduced-pin variants port_d_direction reads zero and ignores writes.
// - Each port_d_analog_select bit set to 1 makes its pin analog with the input off, all reset to 1.
// - On reduced-pin variants port_d_analog_select reads zero and ignores writes.
// - The four lowest second-port pins work as digital pins or capacitive sense channels.
`ifndef PADS_REGS_SVH
`define PADS_REGS_SVH
`define PADS_OFS_B_ANALOG   4'h0
`define PADS_OFS_D_DIR      4'h1
`define PADS_OFS_D_ANALOG   4'h2
`define PADS_OFS_B_IN       4'h3
`define PADS_OFS_D_IN       4'h4
`define PADS_OFS_D_OUT      4'h5
`define PADS_B_ANALOG_MASK  8'h3F
`define PADS_B_ANALOG_RST   8'h3F
`define PADS_D_DIR_RST      8'hFF
`define PADS_D_ANALOG_RST   8'hFF
`define PADS_CAPS_LOW       0
`define PADS_CAPS_COUNT     4
`endif

// >>> pads_pkg.sv
// Types shared by the port analog/direction block
// Assumes the _regs header supplies the constants
package pads_pkg;
	typedef logic [7:0] pads_byte_t;
	typedef logic [3:0] pads_addr_t;
endpackage

// >>> pads_cfg_if.sv
// Carries the per-pin configuration from the register file to the pad logic
// Assumes one clock domain; plain wires only
`timescale 1ns/1ps
interface pads_cfg_if;
	pads_pkg::pads_byte_t b_analog;
	pads_pkg::pads_byte_t d_analog;
	pads_pkg::pads_byte_t d_dir;
	modport regs (output b_analog, output d_analog, output d_dir);
	modport pads (input b_analog, input d_analog, input d_dir);
endinterface

// >>> pads_pin_gate.sv
// Per-pin input gating for both ports and driver enables for the second port
// Assumes configuration bits arrive registered from the register file
`include "pads_regs.svh"
`timescale 1ns/1ps
module pads_pin_gate (
	// Configuration
	pads_cfg_if.pads                 cfg,
	// Raw pad inputs
	input  wire pads_pkg::pads_byte_t b_pad_in,
	input  wire pads_pkg::pads_byte_t d_pad_in,
	// Gated digital inputs and driver enables
	output logic [7:0]                b_dig_in,
	output logic [7:0]                d_dig_in,
	output logic [7:0]                d_drive_en,
	output logic [3:0]                caps_sel
);
	genvar i;
	// One slice per pin: analog mode kills the input buffer
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_pin
			assign b_dig_in[i]   = b_pad_in[i] & ~cfg.b_analog[i];
			assign d_dig_in[i]   = d_pad_in[i] & ~cfg.d_analog[i];
			assign d_drive_en[i] = ~cfg.d_dir[i];
		end
		// Low four pins route to capacitive sense when analog
		for (i = 0; i < `PADS_CAPS_COUNT; i = i + 1) begin : g_caps
			assign caps_sel[i] = cfg.d_analog[`PADS_CAPS_LOW + i];
		end
	endgenerate
endmodule

// >>> pads_port_cfg.sv
// Top of the port analog-select and direction block
// Assumes a simple synchronous register port; reads answer one cycle after the strobe
`include "pads_regs.svh"
`timescale 1ns/1ps
module pads_port_cfg #(
	parameter bit HAS_PORT_D = 1'b1
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Register port
	input  wire pads_pkg::pads_addr_t reg_addr,
	input  wire pads_pkg::pads_byte_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output pads_pkg::pads_byte_t      reg_rdata,
	// Pads
	input  wire pads_pkg::pads_byte_t b_pad_in,
	input  wire pads_pkg::pads_byte_t d_pad_in,
	input  wire pads_pkg::pads_byte_t d_out_data,
	output pads_pkg::pads_byte_t      d_pad_out,
	output pads_pkg::pads_byte_t      d_pad_oe,
	// Analog side and digital consumers
	output pads_pkg::pads_byte_t      b_analog_en,
	output pads_pkg::pads_byte_t      d_analog_en,
	output logic [3:0]                caps_sel,
	output pads_pkg::pads_byte_t      b_dig_in,
	output pads_pkg::pads_byte_t      d_dig_in
);
	pads_cfg_if cfg ();
	pads_pkg::pads_byte_t b_analog;
	pads_pkg::pads_byte_t d_analog;
	pads_pkg::pads_byte_t d_dir;
	pads_pkg::pads_byte_t next_rdata;
	pads_pkg::pads_byte_t b_gate;
	pads_pkg::pads_byte_t d_gate;
	pads_pkg::pads_byte_t d_en;

	// First-port analog bits; upper two never stored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			b_analog <= `PADS_B_ANALOG_RST;
		end else if (reg_wr && reg_addr == `PADS_OFS_B_ANALOG) begin
			b_analog <= reg_wdata & `PADS_B_ANALOG_MASK;
		end
	end

	// Second-port direction; absent on reduced-pin parts
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_dir <= `PADS_D_DIR_RST;
		end else if (HAS_PORT_D && reg_wr && reg_addr == `PADS_OFS_D_DIR) begin
			d_dir <= reg_wdata;
		end
	end

	// Second-port analog bits; absent on reduced-pin parts
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_analog <= `PADS_D_ANALOG_RST;
		end else if (HAS_PORT_D && reg_wr && reg_addr == `PADS_OFS_D_ANALOG) begin
			d_analog <= reg_wdata;
		end
	end

	assign cfg.b_analog = b_analog;
	assign cfg.d_analog = HAS_PORT_D ? d_analog : 8'h00;
	// Missing port is parked as input so nothing drives
	assign cfg.d_dir    = HAS_PORT_D ? d_dir : 8'hFF;

	pads_pin_gate u_gate (
		.cfg        (cfg),
		.b_pad_in   (b_pad_in),
		.d_pad_in   (d_pad_in),
		.b_dig_in   (b_gate),
		.d_dig_in   (d_gate),
		.d_drive_en (d_en),
		.caps_sel   (caps_sel)
	);

	// Read mux; absent and unmapped registers answer zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			`PADS_OFS_B_ANALOG: next_rdata = b_analog & `PADS_B_ANALOG_MASK;
			`PADS_OFS_D_DIR:    next_rdata = HAS_PORT_D ? d_dir : 8'h00;
			`PADS_OFS_D_ANALOG: next_rdata = HAS_PORT_D ? d_analog : 8'h00;
			`PADS_OFS_B_IN:     next_rdata = b_gate;
			`PADS_OFS_D_IN:     next_rdata = HAS_PORT_D ? d_gate : 8'h00;
			`PADS_OFS_D_OUT:    next_rdata = HAS_PORT_D ? d_en : 8'h00;
			default:            next_rdata = 8'h00;
		endcase
	end

	// Read data held one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end

	// Pad-facing outputs; driver stays off while analog is chosen only if software obeys direction
	assign d_pad_oe    = d_en;
	assign d_pad_out   = d_out_data & d_en;
	assign b_analog_en = b_analog;
	assign d_analog_en = cfg.d_analog;
	assign b_dig_in    = b_gate;
	assign d_dig_in    = d_gate;
endmodule

// >>> pads_chk.sv
// Pin-level checks for the port configuration block
// Assumes binding onto pads_port_cfg
`timescale 1ns/1ps
module pads_chk #(parameter bit HAS_PORT_D = 1'b1) (
	// Clock, reset, register port
	input wire logic                 sys_clk, rst_n, reg_wr, reg_rd,
	input wire pads_pkg::pads_addr_t reg_addr,
	input wire pads_pkg::pads_byte_t reg_wdata, reg_rdata,
	// Pads and enables
	input wire pads_pkg::pads_byte_t b_pad_in, d_pad_in, d_out_data, d_pad_out, d_pad_oe,
	input wire pads_pkg::pads_byte_t b_analog_en, d_analog_en, b_dig_in, d_dig_in);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Defaults seen at the first edge after release
	AST_RST_VAL: assert property ($rose(rst_n) |-> b_analog_en == 8'h3F && d_analog_en == 8'hFF)
		else $error("reset value wrong");
	AST_B_WR: assert property (reg_wr && reg_addr == 4'h0 |=> b_analog_en == ($past(reg_wdata) & 8'h3F))
		else $error("b analog write wrong");
	AST_DIR_WR: assert property (HAS_PORT_D && reg_wr && reg_addr == 4'h1 |=> d_pad_oe == ~$past(reg_wdata))
		else $error("direction write wrong");
	AST_AN_WR: assert property (HAS_PORT_D && reg_wr && reg_addr == 4'h2 |=> d_analog_en == $past(reg_wdata))
		else $error("d analog write wrong");
	// Analog pins must read as zero
	AST_B_GATE: assert property (b_dig_in == (b_pad_in & ~b_analog_en))
		else $error("b input gate wrong");
	AST_D_GATE: assert property (d_dig_in == (d_pad_in & ~d_analog_en))
		else $error("d input gate wrong");
	AST_PAD_OUT: assert property (d_pad_out == (d_out_data & d_pad_oe))
		else $error("pad drive wrong");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
	cover property (reg_wr && reg_addr == 4'h2);
	cover property (reg_rd && reg_addr == 4'h4);
	cover property (d_pad_oe != 8'h00);
endmodule
bind pads_port_cfg pads_chk #(.HAS_PORT_D(HAS_PORT_D)) pads_chk_inst (.sys_clk, .rst_n, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .b_pad_in, .d_pad_in, .d_out_data, .d_pad_out, .d_pad_oe,
	.b_analog_en, .d_analog_en, .b_dig_in, .d_dig_in);

// >>> pads_pins_model.sv
// Outside world seen by both ports
// Assumes the bench supplies a fresh source level each step
`timescale 1ns/1ps
module pads_pins_model (
	// Device drive
	input wire pads_pkg::pads_byte_t d_pad_out, d_pad_oe, ext_lvl,
	// Pad levels
	output pads_pkg::pads_byte_t     b_pad_in, d_pad_in);
	// Undriven first-port pins follow the source, undriven second-port pins its inverse, never a stale level
	assign b_pad_in = ext_lvl;
	assign d_pad_in = (d_pad_oe & d_pad_out) | (~d_pad_oe & ~ext_lvl);
endmodule

// >>> tb.sv
// Self-checking bench for the port configuration block
// Assumes the pad model and the bound checker
`timescale 1ns/1ps
module tb;
	// Stimulus, observed outputs, reference copies
	logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] caps_sel;
	logic [31:0] lfsr = 32'he4b3_6b42;
	pads_pkg::pads_addr_t reg_addr = '0;
	pads_pkg::pads_byte_t reg_wdata = '0, d_out_data = '0, ext_lvl = '0, reg_rdata, b_pad_in, d_pad_in;
	pads_pkg::pads_byte_t d_pad_out, d_pad_oe, b_analog_en, d_analog_en, b_dig_in, d_dig_in;
	int n_errors = 0, n_compared = 0, cyc = 0, m_b = 'h3F, m_dir = 'hFF, m_an = 'hFF;
	pads_port_cfg pads_port_cfg_inst (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.b_pad_in, .d_pad_in, .d_out_data, .d_pad_out, .d_pad_oe, .b_analog_en, .d_analog_en, .caps_sel,
		.b_dig_in, .d_dig_in);
	pads_pins_model pads_pins_model_inst (.d_pad_out, .d_pad_oe, .ext_lvl, .b_pad_in, .d_pad_in);
	always #25 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk) if (++cyc == 1000) begin n_errors++; stop_test(); end
	task automatic chk(string nm, int exp, pads_pkg::pads_byte_t got);
		n_compared++;
		if (got !== exp[7:0]) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, exp[7:0], got);
		end
	endtask
	// Next pseudo-random state
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Reference read value per address
	function automatic int exp_rd(int a);
		int dp = ((~m_dir & d_out_data) | (m_dir & ~ext_lvl)) & 'hFF;
		case (a)
			0: return m_b;
			1: return m_dir;
			2: return m_an;
			3: return ext_lvl & ~m_b;
			4: return dp & ~m_an;
			5: return ~m_dir & 'hFF;
			default: return 0;
		endcase
	endfunction
	// Software keeps analog pins as inputs
	task automatic wr(int a, int d);
		if (a == 1) d = d | m_an;
		if (a == 2) d = d & m_dir;
		@(posedge sys_clk) begin reg_wr <= 1; reg_rd <= 0; reg_addr <= a[3:0]; reg_wdata <= d[7:0]; end
		ext_lvl <= lfsr[7:0];
		d_out_data <= lfsr[23:16];
		if (a == 0) m_b = d & 'h3F;
		if (a == 1) m_dir = d & 'hFF;
		if (a == 2) m_an = d & 'hFF;
	endtask
	task automatic rd(int a);
		@(posedge sys_clk) begin reg_rd <= 1; reg_wr <= 0; reg_addr <= a[3:0]; end
		@(posedge sys_clk) reg_rd <= 0;
		#1 chk("rdata", exp_rd(a), reg_rdata);
		chk("caps_sel", m_an & 'hF, {4'h0, caps_sel});
		chk("b_dig_in", exp_rd(3), b_dig_in);
		chk("d_dig_in", exp_rd(4), d_dig_in);
		chk("b_analog_en", m_b, b_analog_en);
		chk("d_analog_en", m_an, d_analog_en);
		chk("d_pad_oe", exp_rd(5), d_pad_oe);
		chk("d_pad_out", exp_rd(5) & d_out_data, d_pad_out);
	endtask
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Defaults incl. unmapped address, then random back-to-back traffic
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1;
		for (int a = 0; a < 8; a++) rd(a);
		$display("test reset done");
		repeat (60) begin
			lfsr = lfsr_next(lfsr);
			wr(lfsr[10:8], lfsr[31:24]);
			rd(lfsr[10:8]);
		end
		$display("test random done");
		stop_test();
	end
endmodule
